/* File: hw/vch_dev.sv */
// Functional notes
// [R1] each picture job completes, then interrupt
// [R2] job inputs latched before start, no host talk
// [R3] host checks ready before new picture command
// [R4] fetch missing standard microcode into program memory
// [R5] per-instance context created and updated per job
// [R6] handle issued only when free; close per instance
// [R7] command register plus shared command I/O registers
// [R8] command I/O overwritten per command, fixed layout
// [R9] global registers untouched by instance switches
// [R10] control register boots controller, shows status
// [R11] one writer per ring pointer
// [R12] stream free space readable any time
// [R13] working and frame buffers device-only during jobs
// [R14] busy set on command, cleared at completion
// [R15] interrupt held until host acknowledge write
module vch_dev
    import vch_pkg::*;
#(
    parameter int NUM_INST = VCH_NUM_INST,
    parameter int UCODE_WORDS = VCH_UCODE_WORDS
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // host interface
    vch_if.dev hif,
    // microcode fetch from shared memory
    output logic mem_rd_out,
    output logic [31:0] mem_addr_out,
    input wire logic [31:0] mem_rdata_in,
    input wire logic mem_rvalid_in,
    // program memory write port
    output logic pm_we_out,
    output logic [$clog2(UCODE_WORDS)-1:0] pm_addr_out,
    output logic [31:0] pm_data_out,
    // picture engine
    output logic job_start_out,
    output logic [$clog2(NUM_INST)-1:0] job_inst_out,
    output logic [VCH_STD_W-1:0] job_std_out,
    output logic [31:0] job_arg_out,
    output logic [VCH_CTX_W-1:0] job_ctx_out,
    output logic [31:0] job_work_base_out,
    input wire logic job_done_in,
    input wire logic [31:0] job_result_in,
    input wire logic job_rd_upd_in,
    input wire logic [31:0] job_rd_ptr_in
);
    localparam int IW = $clog2(UCODE_WORDS);
    localparam int HW = $clog2(NUM_INST);

    typedef enum logic [3:0] {
        DS_IDLE = 4'b0001,
        DS_LREQ = 4'b0010,
        DS_LWAIT = 4'b0100,
        DS_RUN = 4'b1000
    } vch_dst_t;

    typedef struct packed {
        vch_dst_t st;
        logic ack;
        logic [31:0] rdata;
        logic irq;
        logic busy;
        logic pend;
        logic run;
        logic [3:0] cmd;
        logic [2:0][31:0] arg;
        logic [31:0] ucode_base;
        logic [31:0] work_base;
        logic [31:0] glb_opt;
        logic [31:0] bs_rd;
        logic [31:0] bs_wr;
        logic [31:0] bs_size;
        logic res_vld;
        logic [VCH_STD_W-1:0] res_std;
        logic [NUM_INST-1:0] used;
        logic [NUM_INST-1:0][VCH_STD_W-1:0] istd;
        logic [NUM_INST-1:0][VCH_CTX_W-1:0] ctx;
        logic [HW-1:0] cur;
        logic [IW-1:0] idx;
        logic mem_rd;
        logic [31:0] mem_addr;
        logic pm_we;
        logic [IW-1:0] pm_addr;
        logic [31:0] pm_data;
        logic job_start;
        logic [31:0] job_arg;
        logic [VCH_STD_W-1:0] job_std;
        logic [VCH_CTX_W-1:0] job_ctx;
    } vch_dstate_t;

    vch_dstate_t r, n;

    function automatic logic [31:0] free_space(input logic [31:0] rd,
                                               input logic [31:0] wr,
                                               input logic [31:0] size);
        logic [31:0] used;
        used = (wr >= rd) ? (wr - rd) : (size - rd + wr);
        return size - used;
    endfunction

    function automatic logic [31:0] ucode_addr(input logic [31:0] base,
                                               input logic [VCH_STD_W-1:0] std,
                                               input logic [IW-1:0] idx);
        return base + (32'(std) << VCH_UCODE_SHIFT) + (32'(idx) << VCH_WORD_SHIFT);
    endfunction

    always_comb begin
        logic found;
        logic [HW-1:0] h;
        found = 1'b0;
        h = '0;
        n = r;
        n.ack = 1'b0;
        n.mem_rd = 1'b0;
        n.pm_we = 1'b0;
        n.job_start = 1'b0;
        if (hif.req) begin
            n.ack = 1'b1;
            if (hif.we) begin
                case (hif.addr)
                    // [R7] command register write
                    VCH_OFF_CMD: begin
                        // [R3] command while busy dropped
                        if (!r.busy && r.run) begin
                            n.cmd = hif.wdata[3:0];
                            n.pend = 1'b1;
                            // [R14] busy on accept
                            n.busy = 1'b1;
                        end
                    end
                    // [R2] arguments frozen while busy
                    VCH_OFF_ARG0: if (!r.busy) n.arg[0] = hif.wdata;
                    VCH_OFF_ARG1: if (!r.busy) n.arg[1] = hif.wdata;
                    VCH_OFF_ARG2: if (!r.busy) n.arg[2] = hif.wdata;
                    // [R15] acknowledge clears interrupt
                    VCH_OFF_IRQ_ACK: if (hif.wdata[VCH_ACK_BIT]) n.irq = 1'b0;
                    // [R10] controller run enable
                    VCH_OFF_CTRL: n.run = hif.wdata[VCH_CTRL_RUN];
                    // [R9] global registers, host only
                    VCH_OFF_UCODE_BASE: if (!r.busy) n.ucode_base = hif.wdata;
                    // [R13] working buffer fixed during jobs
                    VCH_OFF_WORK_BASE: if (!r.busy) n.work_base = hif.wdata;
                    VCH_OFF_GLB_OPT: n.glb_opt = hif.wdata;
                    // [R11] host owns write pointer only
                    VCH_OFF_BS_WR: n.bs_wr = hif.wdata;
                    VCH_OFF_BS_SIZE: if (!r.busy) n.bs_size = hif.wdata;
                    default: ;
                endcase
            end else begin
                case (hif.addr)
                    VCH_OFF_CMD: n.rdata = {28'h000_0000, r.cmd};
                    VCH_OFF_ARG0: n.rdata = r.arg[0];
                    VCH_OFF_ARG1: n.rdata = r.arg[1];
                    VCH_OFF_ARG2: n.rdata = r.arg[2];
                    // [R10] controller status view
                    VCH_OFF_STATUS: begin
                        n.rdata = '0;
                        n.rdata[VCH_ST_BUSY] = r.busy;
                        n.rdata[VCH_ST_LOADING] = r.st != DS_IDLE && r.st != DS_RUN;
                        n.rdata[VCH_ST_RUN] = r.run;
                        n.rdata[VCH_ST_IRQ] = r.irq;
                    end
                    VCH_OFF_CTRL: n.rdata = {31'h0000_0000, r.run};
                    VCH_OFF_UCODE_BASE: n.rdata = r.ucode_base;
                    VCH_OFF_WORK_BASE: n.rdata = r.work_base;
                    VCH_OFF_GLB_OPT: n.rdata = r.glb_opt;
                    VCH_OFF_BS_RD: n.rdata = r.bs_rd;
                    VCH_OFF_BS_WR: n.rdata = r.bs_wr;
                    VCH_OFF_BS_SIZE: n.rdata = r.bs_size;
                    // [R12] free space on demand
                    VCH_OFF_BS_FREE: n.rdata = free_space(r.bs_rd, r.bs_wr, r.bs_size);
                    default: n.rdata = '0;
                endcase
            end
        end
        // [R11] device owns read pointer
        if (job_rd_upd_in) n.bs_rd = job_rd_ptr_in;
        unique case (r.st)
            DS_IDLE: begin
                if (r.pend) begin
                    n.pend = 1'b0;
                    h = r.arg[0][HW-1:0];
                    // [R8] results overwrite command I/O
                    unique case (r.cmd)
                        VCH_CMD_CREATE: begin
                            for (int i = NUM_INST - 1; i >= 0; i--) begin
                                if (!r.used[i]) begin
                                    found = 1'b1;
                                    h = HW'(i);
                                end
                            end
                            // [R6] handle only when free
                            if (found) begin
                                n.used[h] = 1'b1;
                                n.istd[h] = r.arg[0][VCH_STD_W-1:0];
                                // [R5] context created
                                n.ctx[h] = '0;
                                n.arg[0] = 32'(h);
                                n.arg[1] = VCH_RES_OK;
                            end else begin
                                n.arg[1] = VCH_RES_NO_HANDLE;
                            end
                            n.busy = 1'b0;
                            n.irq = 1'b1;
                        end
                        VCH_CMD_CLOSE: begin
                            // [R6] close one instance
                            n.arg[1] = r.used[h] ? VCH_RES_OK : VCH_RES_BAD_HANDLE;
                            n.used[h] = 1'b0;
                            n.busy = 1'b0;
                            n.irq = 1'b1;
                        end
                        VCH_CMD_PIC_RUN: begin
                            if (!r.used[h]) begin
                                n.arg[1] = VCH_RES_BAD_HANDLE;
                                n.busy = 1'b0;
                                n.irq = 1'b1;
                            end else begin
                                // [R2] job inputs latched
                                n.cur = h;
                                n.job_arg = r.arg[1];
                                n.idx = '0;
                                // [R4] reload on standard change
                                if (r.res_vld && r.res_std == r.istd[h]) begin
                                    n.job_start = 1'b1;
                                    n.st = DS_RUN;
                                end else begin
                                    n.res_vld = 1'b0;
                                    n.st = DS_LREQ;
                                end
                            end
                        end
                        default: begin
                            n.arg[1] = VCH_RES_BAD_CMD;
                            n.busy = 1'b0;
                            n.irq = 1'b1;
                        end
                    endcase
                end
            end
            DS_LREQ: begin
                // [R4] microcode word fetch
                n.mem_rd = 1'b1;
                n.mem_addr = ucode_addr(r.ucode_base, r.istd[r.cur], r.idx);
                n.st = DS_LWAIT;
            end
            DS_LWAIT: begin
                if (mem_rvalid_in) begin
                    n.pm_we = 1'b1;
                    n.pm_addr = r.idx;
                    n.pm_data = mem_rdata_in;
                    if (r.idx == IW'(UCODE_WORDS - 1)) begin
                        n.res_vld = 1'b1;
                        n.res_std = r.istd[r.cur];
                        n.job_start = 1'b1;
                        n.st = DS_RUN;
                    end else begin
                        n.idx = r.idx + 1'b1;
                        n.st = DS_LREQ;
                    end
                end
            end
            DS_RUN: begin
                if (job_done_in) begin
                    // [R5] context updated per job
                    n.ctx[r.cur] = r.ctx[r.cur] + 1'b1;
                    n.arg[0] = job_result_in;
                    n.arg[1] = VCH_RES_OK;
                    n.arg[2] = 32'(n.ctx[r.cur]);
                    // [R14] busy cleared with completion
                    n.busy = 1'b0;
                    // [R1] completion interrupt, wins over ack
                    n.irq = 1'b1;
                    n.st = DS_IDLE;
                end
            end
        endcase
        n.job_std = n.istd[n.cur];
        n.job_ctx = n.ctx[n.cur];
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            r <= '0;
            r.st <= DS_IDLE;
        end else begin
            r <= n;
        end
    end

    assign hif.ack = r.ack;
    assign hif.rdata = r.rdata;
    // [R15] level held until acknowledged
    assign hif.irq = r.irq;
    assign mem_rd_out = r.mem_rd;
    assign mem_addr_out = r.mem_addr;
    assign pm_we_out = r.pm_we;
    assign pm_addr_out = r.pm_addr;
    assign pm_data_out = r.pm_data;
    assign job_start_out = r.job_start;
    assign job_inst_out = r.cur;
    assign job_std_out = r.job_std;
    assign job_arg_out = r.job_arg;
    assign job_ctx_out = r.job_ctx;
    assign job_work_base_out = r.work_base;
endmodule

/* File: hw/vch_pkg.sv */
package vch_pkg;
    localparam int VCH_ADDR_W = 8;
    localparam int VCH_DATA_W = 32;
    // host interface register offsets
    localparam logic [7:0] VCH_OFF_CMD = 8'h00;
    localparam logic [7:0] VCH_OFF_ARG0 = 8'h04;
    localparam logic [7:0] VCH_OFF_ARG1 = 8'h08;
    localparam logic [7:0] VCH_OFF_ARG2 = 8'h0C;
    localparam logic [7:0] VCH_OFF_STATUS = 8'h10;
    localparam logic [7:0] VCH_OFF_IRQ_ACK = 8'h14;
    localparam logic [7:0] VCH_OFF_CTRL = 8'h18;
    localparam logic [7:0] VCH_OFF_UCODE_BASE = 8'h1C;
    localparam logic [7:0] VCH_OFF_WORK_BASE = 8'h20;
    localparam logic [7:0] VCH_OFF_GLB_OPT = 8'h24;
    localparam logic [7:0] VCH_OFF_BS_RD = 8'h28;
    localparam logic [7:0] VCH_OFF_BS_WR = 8'h2C;
    localparam logic [7:0] VCH_OFF_BS_SIZE = 8'h30;
    localparam logic [7:0] VCH_OFF_BS_FREE = 8'h34;
    // command codes
    localparam logic [3:0] VCH_CMD_CREATE = 4'h1;
    localparam logic [3:0] VCH_CMD_CLOSE = 4'h2;
    localparam logic [3:0] VCH_CMD_PIC_RUN = 4'h3;
    // result status codes in ARG1
    localparam logic [31:0] VCH_RES_OK = 32'h0000_0000;
    localparam logic [31:0] VCH_RES_NO_HANDLE = 32'h0000_0001;
    localparam logic [31:0] VCH_RES_BAD_HANDLE = 32'h0000_0002;
    localparam logic [31:0] VCH_RES_BAD_CMD = 32'h0000_0003;
    // status and control bit positions
    localparam int VCH_ST_BUSY = 0;
    localparam int VCH_ST_LOADING = 1;
    localparam int VCH_ST_RUN = 2;
    localparam int VCH_ST_IRQ = 3;
    localparam int VCH_CTRL_RUN = 0;
    localparam int VCH_ACK_BIT = 0;
    // microcode image per coding standard
    localparam int VCH_UCODE_BYTES = 16384;
    localparam int VCH_WORD_BYTES = 4;
    localparam int VCH_UCODE_WORDS = VCH_UCODE_BYTES / VCH_WORD_BYTES;
    localparam int VCH_UCODE_SHIFT = $clog2(VCH_UCODE_BYTES);
    localparam int VCH_WORD_SHIFT = $clog2(VCH_WORD_BYTES);
    localparam int VCH_STD_W = 4;
    localparam int VCH_CTX_W = 16;
    localparam int VCH_NUM_INST = 4;
endpackage

/* File: hw/vch_if.sv */
interface vch_if;
    import vch_pkg::*;
    logic req;
    logic we;
    logic [VCH_ADDR_W-1:0] addr;
    logic [VCH_DATA_W-1:0] wdata;
    logic [VCH_DATA_W-1:0] rdata;
    logic ack;
    logic irq;
    modport dev (
        input req, we, addr, wdata,
        output rdata, ack, irq
    );
    modport host (
        output req, we, addr, wdata,
        input rdata, ack, irq
    );
endinterface

/* File: hw/vch_host.sv */
module vch_host
    import vch_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // device host interface
    vch_if.host hif,
    // command request
    input wire logic cmd_valid_in,
    input wire logic [3:0] cmd_code_in,
    input wire logic [31:0] cmd_arg0_in,
    input wire logic [31:0] cmd_arg1_in,
    output logic cmd_ready_out,
    // command result
    output logic res_valid_out,
    output logic [31:0] res_arg0_out,
    output logic [31:0] res_status_out,
    output logic [31:0] res_ctx_out,
    // plain register write (globals, write pointer)
    input wire logic cfg_valid_in,
    input wire logic [VCH_ADDR_W-1:0] cfg_addr_in,
    input wire logic [31:0] cfg_data_in
);
    typedef enum logic [10:0] {
        HS_IDLE = 11'b000_0000_0001,
        HS_POLL = 11'b000_0000_0010,
        HS_WA0 = 11'b000_0000_0100,
        HS_WA1 = 11'b000_0000_1000,
        HS_WCMD = 11'b000_0001_0000,
        HS_WIRQ = 11'b000_0010_0000,
        HS_ACK = 11'b000_0100_0000,
        HS_RA0 = 11'b000_1000_0000,
        HS_RA1 = 11'b001_0000_0000,
        HS_RA2 = 11'b010_0000_0000,
        HS_CFG = 11'b100_0000_0000
    } vch_hst_t;

    typedef struct packed {
        vch_hst_t st;
        logic outst;
        logic req;
        logic we;
        logic [VCH_ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic [3:0] code;
        logic [31:0] a0;
        logic [31:0] a1;
        logic ready;
        logic res_valid;
        logic [31:0] res_a0;
        logic [31:0] res_st;
        logic [31:0] res_ctx;
    } vch_hstate_t;

    vch_hstate_t r, n;

    always_comb begin
        logic op;
        logic bwe;
        logic [VCH_ADDR_W-1:0] badr;
        logic [31:0] bdat;
        logic done;
        op = 1'b1;
        bwe = 1'b0;
        badr = VCH_OFF_STATUS;
        bdat = '0;
        done = 1'b0;
        n = r;
        n.req = 1'b0;
        n.res_valid = 1'b0;
        unique case (r.st)
            HS_IDLE: op = 1'b0;
            HS_POLL: badr = VCH_OFF_STATUS;
            HS_WA0: begin bwe = 1'b1; badr = VCH_OFF_ARG0; bdat = r.a0; end
            HS_WA1: begin bwe = 1'b1; badr = VCH_OFF_ARG1; bdat = r.a1; end
            HS_WCMD: begin bwe = 1'b1; badr = VCH_OFF_CMD; bdat = 32'(r.code); end
            HS_WIRQ: op = 1'b0;
            HS_ACK: begin
                bwe = 1'b1;
                badr = VCH_OFF_IRQ_ACK;
                bdat = 32'h0000_0001 << VCH_ACK_BIT;
            end
            HS_RA0: badr = VCH_OFF_ARG0;
            HS_RA1: badr = VCH_OFF_ARG1;
            HS_RA2: badr = VCH_OFF_ARG2;
            HS_CFG: begin bwe = 1'b1; badr = r.addr; bdat = r.wdata; end
        endcase
        if (op) begin
            if (!r.outst) begin
                n.req = 1'b1;
                n.we = bwe;
                n.addr = badr;
                n.wdata = bdat;
                n.outst = 1'b1;
            end else if (hif.ack) begin
                n.outst = 1'b0;
                done = 1'b1;
            end
        end
        unique case (r.st)
            HS_IDLE: begin
                if (cmd_valid_in) begin
                    n.code = cmd_code_in;
                    n.a0 = cmd_arg0_in;
                    n.a1 = cmd_arg1_in;
                    n.st = HS_POLL;
                end else if (cfg_valid_in) begin
                    n.addr = cfg_addr_in;
                    n.wdata = cfg_data_in;
                    n.st = HS_CFG;
                end
            end
            // [R3] wait for device not busy
            HS_POLL: if (done && !hif.rdata[VCH_ST_BUSY]) n.st = HS_WA0;
            // [R7] arguments then command code
            HS_WA0: if (done) n.st = HS_WA1;
            HS_WA1: if (done) n.st = HS_WCMD;
            HS_WCMD: if (done) n.st = HS_WIRQ;
            HS_WIRQ: if (hif.irq) n.st = HS_ACK;
            // [R15] acknowledge before reading results
            HS_ACK: if (done) n.st = HS_RA0;
            HS_RA0: if (done) begin n.res_a0 = hif.rdata; n.st = HS_RA1; end
            HS_RA1: if (done) begin n.res_st = hif.rdata; n.st = HS_RA2; end
            HS_RA2: begin
                if (done) begin
                    n.res_ctx = hif.rdata;
                    n.res_valid = 1'b1;
                    n.st = HS_IDLE;
                end
            end
            HS_CFG: if (done) n.st = HS_IDLE;
        endcase
        n.ready = n.st == HS_IDLE;
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            r <= '0;
            r.st <= HS_IDLE;
            r.ready <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign hif.req = r.req;
    assign hif.we = r.we;
    assign hif.addr = r.addr;
    assign hif.wdata = r.wdata;
    assign cmd_ready_out = r.ready;
    assign res_valid_out = r.res_valid;
    assign res_arg0_out = r.res_a0;
    assign res_status_out = r.res_st;
    assign res_ctx_out = r.res_ctx;
endmodule

/* File: testbench/vch_checker.sv */
module vch_checker
    import vch_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // register bus
    input wire logic req,
    input wire logic we,
    input wire logic [VCH_ADDR_W-1:0] addr,
    input wire logic [VCH_DATA_W-1:0] wdata,
    input wire logic [VCH_DATA_W-1:0] rdata,
    input wire logic ack,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic cmd_wr = req && we && addr == VCH_OFF_CMD;
    wire logic ack_wr = req && we && addr == VCH_OFF_IRQ_ACK && wdata[VCH_ACK_BIT];
    logic job_open_reg;
    always_ff @(posedge clk_sys_in) begin
        if (rst_in || irq) begin
            job_open_reg <= 1'b0;
        end else if (cmd_wr) begin
            job_open_reg <= 1'b1;
        end
    end
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);
    AST_ACK_NEXT: assert property (req |=> ack)
        else $error("ack missing after request");
    AST_ACK_CAUSE: assert property (ack |-> $past(req))
        else $error("ack without request");
    AST_REQ_GAP: assert property (req |=> !req)
        else $error("requests too close");
    AST_RDATA_HOLD: assert property ($changed(rdata) |-> ack && !$past(we))
        else $error("read data changed outside read answer");
    AST_IRQ_HOLD: assert property (irq && !ack_wr |=> irq)
        else $error("interrupt dropped without acknowledge");
    AST_IRQ_CLEAR: assert property (ack_wr |=> !irq)
        else $error("interrupt not cleared by acknowledge");
    AST_JOB_QUIET: assert property (job_open_reg && !irq |-> !req)
        else $error("bus traffic during running command");
    AST_CMD_DONE: assert property (cmd_wr |-> ##[2:600] irq)
        else $error("command without completion interrupt");
    cover property (cmd_wr ##[2:600] irq);
    cover property (ack_wr);
    cover property (req && !we ##1 ack);
endmodule

/* File: testbench/video_codec_host_command_port_bench.sv */
module video_codec_host_command_port_bench;
    import vch_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] UB = 32'h0004_0000;
    localparam logic [31:0] WB = 32'h0080_0000;
    logic clk_sys_in, rst_in, cmd_valid_in, cfg_valid_in, cmd_ready_out, res_valid_out;
    logic mem_rd_out, mem_rvalid_in, pm_we_out, job_start_out, job_done_in;
    logic [3:0] cmd_code_in, job_std_out, exp_std;
    logic [7:0] cfg_addr_in;
    logic [1:0] pm_addr_out, job_inst_out, exp_inst;
    logic [15:0] job_ctx_out, exp_ctx;
    logic [31:0] cmd_arg0_in, cmd_arg1_in, cfg_data_in, res_arg0_out, res_status_out;
    logic [31:0] res_ctx_out, mem_addr_out, mem_rdata_in, pm_data_out, job_arg_out;
    logic [31:0] job_work_base_out, job_result_in;
    int failures, n_compared, pm_cnt, h;
    vch_if bus();
    vch_dev #(.NUM_INST(4), .UCODE_WORDS(4)) i_vch_dev (.clk_sys_in(clk_sys_in),
        .rst_in(rst_in), .hif(bus), .mem_rd_out(mem_rd_out), .mem_addr_out(mem_addr_out),
        .mem_rdata_in(mem_rdata_in), .mem_rvalid_in(mem_rvalid_in), .pm_we_out(pm_we_out),
        .pm_addr_out(pm_addr_out), .pm_data_out(pm_data_out), .job_start_out(job_start_out),
        .job_inst_out(job_inst_out), .job_std_out(job_std_out), .job_arg_out(job_arg_out),
        .job_ctx_out(job_ctx_out), .job_work_base_out(job_work_base_out),
        .job_done_in(job_done_in), .job_result_in(job_result_in), .job_rd_upd_in(1'b0),
        .job_rd_ptr_in(32'h0000_0000));
    vch_host i_vch_host (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .hif(bus),
        .cmd_valid_in(cmd_valid_in), .cmd_code_in(cmd_code_in), .cmd_arg0_in(cmd_arg0_in),
        .cmd_arg1_in(cmd_arg1_in), .cmd_ready_out(cmd_ready_out),
        .res_valid_out(res_valid_out), .res_arg0_out(res_arg0_out),
        .res_status_out(res_status_out), .res_ctx_out(res_ctx_out),
        .cfg_valid_in(cfg_valid_in), .cfg_addr_in(cfg_addr_in), .cfg_data_in(cfg_data_in));
    vch_checker i_vch_checker (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .req(bus.req),
        .we(bus.we), .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata),
        .ack(bus.ack), .irq(bus.irq));
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string name);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wait_sel(input bit res);
        int i;
        for (i = 0; i < 2000; i++) begin
            if ((res ? res_valid_out : cmd_ready_out) === 1'b1) return;
            @(negedge clk_sys_in);
        end
        chk(32'h0000_0000, 32'h0000_0001, "wait limit");
        finish_test();
    endtask
    task automatic cfg(input logic [7:0] a, input logic [31:0] d);
        wait_sel(1'b0);
        cfg_valid_in = 1'b1;
        cfg_addr_in = a;
        cfg_data_in = d;
        @(negedge clk_sys_in);
        cfg_valid_in = 1'b0;
        @(negedge clk_sys_in);
    endtask
    task automatic run_cmd(input logic [3:0] c, input logic [31:0] a0, input logic [31:0] a1);
        wait_sel(1'b0);
        cmd_valid_in = 1'b1;
        cmd_code_in = c;
        cmd_arg0_in = a0;
        cmd_arg1_in = a1;
        @(negedge clk_sys_in);
        cmd_valid_in = 1'b0;
        wait_sel(1'b1);
    endtask
    task automatic pic(input logic [1:0] hd, input logic [3:0] s, input logic [15:0] c,
            input int loads);
        logic [31:0] arg;
        arg = {14'h0000, hd, c};
        exp_std = s;
        exp_inst = hd;
        exp_ctx = c;
        pm_cnt = 0;
        run_cmd(VCH_CMD_PIC_RUN, {30'h0000_0000, hd}, arg);
        chk(res_arg0_out, arg + 32'h0000_0100, "result");
        chk(res_status_out, VCH_RES_OK, "status");
        chk(res_ctx_out, {16'h0000, c + 16'h0001}, "frames");
        chk(32'(pm_cnt), 32'(loads), "ucode words");
    endtask
    initial begin
        clk_sys_in = 1'b0;
        forever #10 clk_sys_in = ~clk_sys_in;
    end
    // memory returns its own address as data
    always @(negedge clk_sys_in) if (mem_rd_out === 1'b1) begin
        mem_rdata_in = mem_addr_out;
        mem_rvalid_in = 1'b1;
        @(negedge clk_sys_in);
        mem_rvalid_in = 1'b0;
        mem_rdata_in = ~mem_addr_out;
    end
    always @(negedge clk_sys_in) if (pm_we_out === 1'b1) begin
        chk(32'(pm_addr_out), 32'(pm_cnt), "pm index");
        chk(pm_data_out, UB + {exp_std, 14'h0000} + 32'(pm_cnt * 4), "ucode");
        pm_cnt++;
    end
    // picture engine stand-in
    always @(negedge clk_sys_in) if (job_start_out === 1'b1) begin
        chk(32'(job_inst_out), 32'(exp_inst), "instance");
        chk(32'(job_std_out), 32'(exp_std), "standard");
        chk(32'(job_ctx_out), 32'(exp_ctx), "context");
        chk(job_work_base_out, WB, "work base");
        repeat (5) @(negedge clk_sys_in);
        job_result_in = job_arg_out + 32'h0000_0100;
        job_done_in = 1'b1;
        @(negedge clk_sys_in);
        job_done_in = 1'b0;
    end
    initial begin
        {cmd_valid_in, cfg_valid_in, mem_rvalid_in, job_done_in} = 4'h0;
        {cmd_code_in, cfg_addr_in, exp_std, exp_inst, exp_ctx} = 34'h0_0000_0000;
        {cmd_arg0_in, cmd_arg1_in, cfg_data_in, mem_rdata_in, job_result_in} = '0;
        failures = 0;
        n_compared = 0;
        pm_cnt = 0;
        rst_in = 1'b1;
        repeat (20) @(negedge clk_sys_in);
        rst_in = 1'b0;
        chk(32'(cmd_ready_out), 32'h0000_0001, "ready");
        cfg(VCH_OFF_CTRL, 32'h0000_0001);
        cfg(VCH_OFF_UCODE_BASE, UB);
        cfg(VCH_OFF_WORK_BASE, WB);
        for (h = 0; h < 4; h++) begin
            run_cmd(VCH_CMD_CREATE, 32'(h + 2), 32'h0000_0000);
            chk(res_arg0_out, 32'(h), "handle");
            chk(res_status_out, VCH_RES_OK, "create");
        end
        run_cmd(VCH_CMD_CREATE, 32'h0000_0007, 32'h0000_0000);
        chk(res_status_out, VCH_RES_NO_HANDLE, "create full");
        pic(2'd0, 4'h2, 16'h0000, 4);
        pic(2'd0, 4'h2, 16'h0001, 0);
        pic(2'd1, 4'h3, 16'h0000, 4);
        pic(2'd0, 4'h2, 16'h0002, 4);
        run_cmd(VCH_CMD_CLOSE, 32'h0000_0001, 32'h0000_0000);
        chk(res_status_out, VCH_RES_OK, "close");
        run_cmd(VCH_CMD_CLOSE, 32'h0000_0001, 32'h0000_0000);
        chk(res_status_out, VCH_RES_BAD_HANDLE, "close again");
        run_cmd(VCH_CMD_PIC_RUN, 32'h0000_0001, 32'h0000_0000);
        chk(res_status_out, VCH_RES_BAD_HANDLE, "run closed");
        run_cmd(4'h7, 32'h0000_0000, 32'h0000_0000);
        chk(res_status_out, VCH_RES_BAD_CMD, "bad code");
        run_cmd(VCH_CMD_CREATE, 32'h0000_0005, 32'h0000_0000);
        chk(res_arg0_out, 32'h0000_0001, "reuse handle");
        finish_test();
    end
endmodule
